//--- rtl/pmca_monitor.sv
`default_nettype none
// ==========================================================================
// measurement sequencer, averaging and alert logic
//
// Contract
// [R1] mode 111 repeats shunt then bus conversions without host action
// [R2] current follows each shunt sample, power follows each bus sample
// [R3] zero calibration gives zero current and zero power
// [R4] samples accumulate; outputs load only after the averaging count
// [R5] outputs hold until next full result; reads never disturb conversion
// [R6] modes exist for shunt only or bus only, triggered and continuous
// [R7] current and power math adds no time to the conversion period
// [R8] each triggered-mode config write starts exactly one measurement set
// [R9] power-down stops conversions, registers stay usable, 40 us recovery
// [R10] ready flag sets only after conversions, averaging and math finish
// [R11] ready flag clears on non power-down config write or mask read
// [R12] one of five limit functions active; highest enabled bit wins
// [R13] open-drain alert asserts when watched quantity crosses the limit
// [R14] host reads mask register after alert to learn its cause
// [R15] with ready-on-alert clear, alert follows only the limit function
// [R16] shunt limits compare after every shunt conversion, flag on exceed
// [R17] alert active level follows the polarity bit
// [R18] latched flag and alert hold until config write or mask read
// [R19] bus limits compare after every bus conversion
// [R20] power limit compares new power after every bus conversion
// [R21] bus code step is 1.25 mV, full scale 40.96 V
// [R22] power step equals 25 times the current step
// [R23] host computes calibration as 0.00512 over current step times shunt
// [R24] unlatched flag and alert follow each new comparison result
module pmca_monitor #(
  parameter int unsigned RECOVERY_CYCLES = pmca_pkg::RECOVERY_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_data,
  output logic             conv_start,
  output logic             conv_bus,
  output logic      [2:0]  conv_time,
  output logic             adc_sleep,
  output logic             alert_out,
  output logic             alert_oe
);

  localparam int unsigned WAKE_W = $clog2(RECOVERY_CYCLES + 1);
  localparam logic [WAKE_W-1:0] WAKE_LOAD = WAKE_W'(RECOVERY_CYCLES - 1);

  typedef enum logic [2:0] {ST_SLEEP, ST_WAKE, ST_IDLE, ST_SHUNT, ST_BUS} pmca_state_e;

  pmca_state_e        state;
  pmca_state_e        next_state;
  logic [WAKE_W-1:0]  wake_cnt;
  logic [15:0]        cfg;
  logic [15:0]        cal;
  logic [15:0]        mask_ctl;
  logic [15:0]        limit;
  logic [15:0]        shunt_res;
  logic [15:0]        bus_res;
  logic [15:0]        cur_res;
  logic [15:0]        pwr_res;
  logic signed [15:0] cur_latest;
  logic signed [25:0] acc_shunt;
  logic signed [25:0] acc_cur;
  logic [25:0]        acc_bus;
  logic [25:0]        acc_pwr;
  logic [10:0]        sample_cnt;
  logic               load_pending;
  logic               ready_flag;
  logic               limit_flag;

  // ==========================================================================
  // register port decode
  wire        cfg_wr    = reg_wr && (reg_addr == pmca_pkg::ADDR_CFG);
  wire        cal_wr    = reg_wr && (reg_addr == pmca_pkg::ADDR_CAL);
  wire        mask_wr   = reg_wr && (reg_addr == pmca_pkg::ADDR_MASK);
  wire        limit_wr  = reg_wr && (reg_addr == pmca_pkg::ADDR_LIMIT);
  wire        mask_rd   = reg_rd && (reg_addr == pmca_pkg::ADDR_MASK);
  wire [2:0]  mode      = cfg[pmca_pkg::CFG_MODE_LSB +: 3];
  wire [2:0]  new_mode  = reg_wdata[pmca_pkg::CFG_MODE_LSB +: 3];
  wire        new_pd    = !(new_mode[pmca_pkg::MODE_SHUNT] || new_mode[pmca_pkg::MODE_BUS]);
  wire [3:0]  avg_sh    = pmca_pkg::avg_shift(cfg[pmca_pkg::CFG_AVG_LSB +: 3]);
  wire        latch_en  = mask_ctl[pmca_pkg::MSK_LEN];
  wire [15:0] mask_view = mask_ctl
                        | (16'(limit_flag) << pmca_pkg::MSK_AFF)
                        | (16'(ready_flag) << pmca_pkg::MSK_CONVERSION_READY_FLAG);  // R14

  // readback selection; unmapped offsets read zero
  wire [15:0] rd_mux =
    (reg_addr == pmca_pkg::ADDR_CFG)     ? cfg       :
    (reg_addr == pmca_pkg::ADDR_SHUNT)   ? shunt_res :
    (reg_addr == pmca_pkg::ADDR_BUS)     ? bus_res   :
    (reg_addr == pmca_pkg::ADDR_POWER)   ? pwr_res   :
    (reg_addr == pmca_pkg::ADDR_CURRENT) ? cur_res   :
    (reg_addr == pmca_pkg::ADDR_CAL)     ? cal       :
    (reg_addr == pmca_pkg::ADDR_MASK)    ? mask_view :
    (reg_addr == pmca_pkg::ADDR_LIMIT)   ? limit     : 16'h0000;

  // ==========================================================================
  // per-sample arithmetic, done in the cycle the sample arrives
  wire                cal_zero   = (cal[14:0] == 15'h0000);
  wire signed [15:0]  shunt_s    = conv_data;
  wire signed [16:0]  cal_s      = {2'b00, cal[14:0]};
  wire signed [32:0]  cur_prod   = shunt_s * cal_s;                      // R7
  wire signed [15:0]  cur_calc   = cal_zero ? 16'sh0000 :
                                   cur_prod[pmca_pkg::CUR_SHIFT +: 16];  // R2 R3
  wire [15:0]         bus_code   = {1'b0, conv_data[pmca_pkg::BUS_CODE_W-1:0]};  // R21
  wire [15:0]         cur_abs    = cur_latest[15] ? 16'(-cur_latest) : cur_latest;
  wire [30:0]         pwr_prod   = cur_abs * bus_code[pmca_pkg::BUS_CODE_W-1:0];
  wire [30:0]         pwr_quot   = pwr_prod / 31'(pmca_pkg::POWER_DIV);  // R22
  wire [15:0]         pwr_calc   = cal_zero ? 16'h0000 : pwr_quot[15:0]; // R2 R3

  // ==========================================================================
  // sequencing events
  wire sh_done   = (state == ST_SHUNT) && conv_done;
  wire bus_done  = (state == ST_BUS) && conv_done;
  wire set_end   = (sh_done && !mode[pmca_pkg::MODE_BUS]) || bus_done;
  wire avg_last  = (sample_cnt == 11'((11'd1 << avg_sh) - 11'd1));
  wire set_full  = set_end && avg_last;                                  // R4
  wire in_conv   = (state == ST_SHUNT) || (state == ST_BUS);
  wire nx_conv   = (next_state == ST_SHUNT) || (next_state == ST_BUS);
  wire restart   = cfg_wr && !new_pd;
  pmca_state_e first_new;
  pmca_state_e first_cur;
  assign first_new = new_mode[pmca_pkg::MODE_SHUNT] ? ST_SHUNT : ST_BUS;
  assign first_cur = mode[pmca_pkg::MODE_SHUNT] ? ST_SHUNT : ST_BUS;   // R6

  // next state of the conversion sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_SLEEP: begin
        if (restart) next_state = ST_WAKE;                               // R9
      end
      ST_WAKE: begin
        if (cfg_wr && new_pd) next_state = ST_SLEEP;
        else if (wake_cnt == '0) next_state = first_cur;                 // R9
      end
      ST_IDLE: begin
        if (cfg_wr) next_state = new_pd ? ST_SLEEP : first_new;          // R8
      end
      ST_SHUNT, ST_BUS: begin
        if (cfg_wr) next_state = new_pd ? ST_SLEEP : first_new;          // R8 R9
        else if (set_end) begin
          // a triggered set still runs every sample of the averaging count
          next_state = (mode[pmca_pkg::MODE_CONT] || !avg_last) ? first_cur : ST_IDLE;  // R1 R8
        end else if (sh_done) next_state = ST_BUS;                       // R1
      end
    endcase
  end

  // state, wake timer and start pulse
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state      <= ST_WAKE;
      wake_cnt   <= WAKE_LOAD;
      conv_start <= 1'b0;
    end else begin
      state      <= next_state;
      wake_cnt   <= (next_state == ST_WAKE && state != ST_WAKE) ? WAKE_LOAD :
                    (wake_cnt != '0) ? wake_cnt - 1'b1 : wake_cnt;
      conv_start <= nx_conv && (!in_conv || conv_done || cfg_wr);
    end
  end

  // converter control seen from the current state
  assign conv_bus  = (state == ST_BUS);
  assign conv_time = conv_bus ? cfg[pmca_pkg::CFG_BUSCT_LSB +: 3]
                              : cfg[pmca_pkg::CFG_SHCT_LSB +: 3];
  assign adc_sleep = (state == ST_SLEEP);                                // R9

  // ==========================================================================
  // host-written registers, usable in every state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg      <= pmca_pkg::CFG_RESET;
      cal      <= pmca_pkg::REG_RESET;
      mask_ctl <= pmca_pkg::REG_RESET;
      limit    <= pmca_pkg::REG_RESET;
    end else begin
      if (cfg_wr) cfg <= reg_wdata;
      if (cal_wr) cal <= reg_wdata;
      if (mask_wr) mask_ctl <= reg_wdata & pmca_pkg::MSK_WRITABLE;
      if (limit_wr) limit <= reg_wdata;
    end
  end

  // read data capture; reads only sample, never touch the sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) reg_rdata <= 16'h0000;
    else if (reg_rd) reg_rdata <= rd_mux;                                // R5
  end

  // ==========================================================================
  // accumulators; cleared on restart and after each averaged load
  wire clr_acc = restart || load_pending;
  always_ff @(posedge ref_clk) begin
    if (rst || clr_acc) begin
      acc_shunt <= 26'sh0;
      acc_cur   <= 26'sh0;
    end else if (sh_done) begin
      acc_shunt <= acc_shunt + {{10{shunt_s[15]}}, shunt_s};            // R4
      acc_cur   <= acc_cur + {{10{cur_calc[15]}}, cur_calc};            // R4
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || clr_acc) begin
      acc_bus <= 26'h0;
      acc_pwr <= 26'h0;
    end else if (bus_done) begin
      acc_bus <= acc_bus + {10'h000, bus_code};                         // R4
      acc_pwr <= acc_pwr + {10'h000, pwr_calc};                         // R4
    end
  end

  // latest current feeds the next power product
  always_ff @(posedge ref_clk) begin
    if (rst) cur_latest <= 16'sh0000;
    else if (sh_done) cur_latest <= cur_calc;                            // R2
  end

  // sample count and the one-cycle load request after the last sample
  always_ff @(posedge ref_clk) begin
    if (rst || restart) begin
      sample_cnt   <= 11'h000;
      load_pending <= 1'b0;
    end else begin
      sample_cnt   <= set_full ? 11'h000 : set_end ? sample_cnt + 11'd1 : sample_cnt;
      load_pending <= set_full;
    end
  end

  // averaged outputs replace the old ones only on a completed set
  wire [25:0] avg_shunt = 26'(acc_shunt >>> avg_sh);
  wire [25:0] avg_cur   = 26'(acc_cur >>> avg_sh);
  wire [25:0] avg_bus   = acc_bus >> avg_sh;
  wire [25:0] avg_pwr   = acc_pwr >> avg_sh;
  wire        load_sh   = load_pending && mode[pmca_pkg::MODE_SHUNT];
  wire        load_bus  = load_pending && mode[pmca_pkg::MODE_BUS];
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shunt_res <= pmca_pkg::REG_RESET;
      cur_res   <= pmca_pkg::REG_RESET;
      bus_res   <= pmca_pkg::REG_RESET;
      pwr_res   <= pmca_pkg::REG_RESET;
    end else begin
      if (load_sh) shunt_res <= avg_shunt[15:0];                         // R5
      if (load_sh) cur_res <= avg_cur[15:0];
      if (load_bus) bus_res <= avg_bus[15:0];                            // R5
      if (load_bus) pwr_res <= avg_pwr[15:0];
    end
  end

  // ==========================================================================
  // ready flag; a set in the same cycle as a clear wins
  always_ff @(posedge ref_clk) begin
    if (rst) ready_flag <= 1'b0;
    else if (load_pending) ready_flag <= 1'b1;                           // R10
    else if (restart || mask_rd) ready_flag <= 1'b0;                     // R11
  end

  // ==========================================================================
  // limit function selection, highest enabled bit governs
  wire en_sol = mask_ctl[pmca_pkg::MSK_SOL];                             // R12
  wire en_sul = mask_ctl[pmca_pkg::MSK_SUL] && !en_sol;
  wire en_bol = mask_ctl[pmca_pkg::MSK_BOL] && !mask_ctl[pmca_pkg::MSK_SUL] && !en_sol;
  wire en_bul = mask_ctl[pmca_pkg::MSK_BUL] && !(|mask_ctl[15:13]);
  wire en_pol = mask_ctl[pmca_pkg::MSK_POL] && !(|mask_ctl[15:12]);

  // comparison moments and outcome
  wire cmp_event = (sh_done && (en_sol || en_sul))                       // R16
                || (bus_done && (en_bol || en_bul || en_pol));           // R19 R20
  wire exceed    = (en_sol && (shunt_s > $signed(limit)))                // R16
                || (en_sul && (shunt_s < $signed(limit)))
                || (en_bol && (bus_code > limit))                        // R19
                || (en_bul && (bus_code < limit))
                || (en_pol && (pwr_calc > limit));                       // R20

  // limit flag: latched holds until host clears, unlatched tracks compares
  always_ff @(posedge ref_clk) begin
    if (rst) limit_flag <= 1'b0;
    else if (cmp_event && exceed) limit_flag <= 1'b1;                    // R13
    else if (cmp_event && !latch_en) limit_flag <= 1'b0;                 // R24
    else if (latch_en && (cfg_wr || mask_rd)) limit_flag <= 1'b0;        // R18
  end

  // ==========================================================================
  // open-drain alert; enable high pulls the pin low
  wire alert_act = limit_flag
                || (mask_ctl[pmca_pkg::MSK_READY_ON_ALERT_ENABLE] && ready_flag);         // R15
  always_ff @(posedge ref_clk) begin
    if (rst) alert_oe <= 1'b0;
    else alert_oe <= mask_ctl[pmca_pkg::MSK_ALERT_ACTIVE_LEVEL] ? !alert_act : alert_act;  // R13 R17
  end
  assign alert_out = 1'b0;                                               // R13

endmodule
`default_nettype wire

//--- rtl/pmca_pkg.sv
`default_nettype none
// ==========================================================================
// shared constants of the power monitor sequencer
package pmca_pkg;

  // register offsets on the internal register port
  localparam logic [7:0] ADDR_CFG     = 8'h00;
  localparam logic [7:0] ADDR_SHUNT   = 8'h01;
  localparam logic [7:0] ADDR_BUS     = 8'h02;
  localparam logic [7:0] ADDR_POWER   = 8'h03;
  localparam logic [7:0] ADDR_CURRENT = 8'h04;
  localparam logic [7:0] ADDR_CAL     = 8'h05;
  localparam logic [7:0] ADDR_MASK    = 8'h06;
  localparam logic [7:0] ADDR_LIMIT   = 8'h07;

  // operating_configuration fields
  localparam int unsigned CFG_MODE_LSB  = 0;
  localparam int unsigned CFG_SHCT_LSB  = 3;
  localparam int unsigned CFG_BUSCT_LSB = 6;
  localparam int unsigned CFG_AVG_LSB   = 9;
  localparam logic [15:0] CFG_RESET     = 16'h0007;
  localparam logic [2:0]  MODE_CONT_ALL = 3'b111;
  localparam int unsigned MODE_SHUNT    = 0;
  localparam int unsigned MODE_BUS      = 1;
  localparam int unsigned MODE_CONT     = 2;

  // alert_mask_enable fields
  localparam int unsigned MSK_SOL  = 15;
  localparam int unsigned MSK_SUL  = 14;
  localparam int unsigned MSK_BOL  = 13;
  localparam int unsigned MSK_BUL  = 12;
  localparam int unsigned MSK_POL  = 11;
  localparam int unsigned MSK_READY_ON_ALERT_ENABLE = 10;
  localparam int unsigned MSK_AFF  = 4;
  localparam int unsigned MSK_CONVERSION_READY_FLAG = 3;
  localparam int unsigned MSK_ALERT_ACTIVE_LEVEL = 1;
  localparam int unsigned MSK_LEN  = 0;
  localparam logic [15:0] MSK_WRITABLE = 16'hFC03;
  localparam logic [15:0] REG_RESET    = 16'h0000;

  // arithmetic scaling
  localparam int unsigned CUR_SHIFT          = 11;
  localparam int unsigned BUS_LSB_UV         = 1250;
  localparam int unsigned BUS_FULL_SCALE_MV  = 40960;
  localparam int unsigned BUS_CODE_W         = 15;
  localparam int unsigned BUS_CODES_PER_V    = 1000000 / BUS_LSB_UV;
  localparam int unsigned POWER_STEP_MULT    = 25;
  localparam int unsigned POWER_DIV          = POWER_STEP_MULT * BUS_CODES_PER_V;

  // timing at 200 MHz
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned RECOVERY_NS      = 40000;
  localparam int unsigned RECOVERY_CYCLES  = RECOVERY_NS * CLK_MHZ / 1000;

  // averaging code to log2 of the sample count
  function automatic logic [3:0] avg_shift(input logic [2:0] code);
    logic [3:0] sh;
    sh = 4'h0;
    case (code)
      3'd0: sh = 4'd0;
      3'd1: sh = 4'd2;
      3'd2: sh = 4'd4;
      3'd3: sh = 4'd6;
      3'd4: sh = 4'd7;
      3'd5: sh = 4'd8;
      3'd6: sh = 4'd9;
      default: sh = 4'd10;
    endcase
    return sh;
  endfunction

endpackage
`default_nettype wire

//--- tb/pmca_conv_model.sv
`default_nettype none
// ==========================================================================
// converter model: answers each start after a prompt or slow delay
module pmca_conv_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        conv_start,
  input  wire logic        conv_bus,
  input  wire logic        slow,
  input  wire logic [15:0] shunt_val,
  input  wire logic [15:0] bus_val,
  output logic             conv_done,
  output logic      [15:0] conv_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int   left;
  logic ch;
  // a fresh start restarts the conversion; idle data toggles every cycle
  always @(posedge ref_clk) begin
    conv_done <= 1'b0;
    conv_data <= ~conv_data;
    if (rst) begin
      left <= 0;
      conv_data <= 16'h0000;
    end else if (conv_start) begin
      left <= slow ? 20 : 6;
      ch <= conv_bus;
    end else if (left == 1) begin
      left <= 0;
      conv_done <= 1'b1;
      conv_data <= ch ? bus_val : shunt_val;
    end else if (left > 1) begin
      left <= left - 1;
    end
  end
endmodule
`default_nettype wire

//--- tb/pmca_monitor_assertions.sv
`default_nettype none
// ==========================================================================
// sequencing and alert checks on the monitor ports
module pmca_monitor_assertions #(
  parameter int unsigned RECOVERY_CYCLES = 4
) (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        conv_done,
  input wire logic [15:0] conv_data,
  input wire logic        conv_start,
  input wire logic        conv_bus,
  input wire logic [2:0]  conv_time,
  input wire logic        adc_sleep,
  input wire logic        alert_out,
  input wire logic        alert_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cfg_sh;
  logic [15:0] msk_sh;
  logic [15:0] lim_sh;
  wire         cfg_wr = reg_wr && reg_addr == 8'h00;
  wire         act_wr = cfg_wr && reg_wdata[1:0] != 2'b00;
  // shadows of the config, mask and limit registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_sh <= pmca_pkg::CFG_RESET;
      msk_sh <= 16'h0000;
      lim_sh <= 16'h0000;
    end else begin
      if (cfg_wr) cfg_sh <= reg_wdata;
      if (reg_wr && reg_addr == 8'h06) msk_sh <= reg_wdata & pmca_pkg::MSK_WRITABLE;
      if (reg_wr && reg_addr == 8'h07) lim_sh <= reg_wdata;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence shunt_done_s;
    conv_done && !conv_bus && !reg_wr;
  endsequence
  sequence bus_done_s;
    conv_done && conv_bus && !reg_wr;
  endsequence
  // ==========================================================================
  // conversion sequencing
  sleep_quiet_a: assert property (adc_sleep |-> !conv_start)
    else $error("start while asleep");
  sleep_entry_a: assert property (cfg_wr && reg_wdata[1:0] == 2'b00 |=> ##[0:1] adc_sleep)
    else $error("no sleep after power-down write");
  wake_wait_a: assert property (act_wr && adc_sleep && RECOVERY_CYCLES > 1 |=> !conv_start)
    else $error("start without recovery");
  trig_start_a: assert property (act_wr && !adc_sleep |=> conv_start)
    else $error("no start after config write");
  mode_channel_a: assert property (
    conv_start && cfg_sh[1:0] != 2'b11 |-> conv_bus == cfg_sh[1])
    else $error("wrong channel for mode");
  conv_time_a: assert property (
    conv_start |-> conv_time == (conv_bus ? cfg_sh[8:6] : cfg_sh[5:3]))
    else $error("conversion time field not applied");
  shunt_bus_a: assert property (
    shunt_done_s ##0 (cfg_sh[1:0] == 2'b11) |=> conv_start && conv_bus)
    else $error("bus does not follow shunt");
  set_end_a: assert property (
    bus_done_s ##0 (!cfg_sh[2] && cfg_sh[11:9] == 3'd0) |=> !conv_start)
    else $error("extra start after single set");
  // ==========================================================================
  // alert output
  sol_alert_a: assert property (shunt_done_s ##0 (msk_sh[15:10] == 6'h20 &&
    $signed(conv_data) > $signed(lim_sh)) ##1 !reg_wr |=> alert_oe != msk_sh[1])
    else $error("shunt over not signalled");
  sol_clear_a: assert property (shunt_done_s ##0 (msk_sh == 16'h8000 &&
    $signed(conv_data) <= $signed(lim_sh)) ##1 !reg_wr |=> !alert_oe)
    else $error("alert stuck without latch");
  bol_alert_a: assert property (bus_done_s ##0 (msk_sh[15:11] == 5'h04 &&
    {1'b0, conv_data[14:0]} > lim_sh) ##1 !reg_wr |=> alert_oe != msk_sh[1])
    else $error("bus over not signalled");
  drain_low_a: assert property (alert_oe |-> alert_out == 1'b0)
    else $error("alert not open drain");
endmodule
bind pmca_monitor pmca_monitor_assertions #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) chk (
  .ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_done(conv_done),
  .conv_data(conv_data), .conv_start(conv_start), .conv_bus(conv_bus),
  .conv_time(conv_time), .adc_sleep(adc_sleep), .alert_out(alert_out), .alert_oe(alert_oe));
`default_nettype wire

//--- tb/pmca_monitor_test.sv
`default_nettype none
// ==========================================================================
// bench: register calls against the converter model
module pmca_monitor_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] AMASK [12] = '{16'h8000, 16'h8000, 16'hC000, 16'h4000, 16'h4000,
    16'h2000, 16'h1000, 16'h0800, 16'h0800, 16'h8003, 16'h0400, 16'h0000};
  localparam logic [15:0] ALIM [12] = '{16'h0080, 16'h0200, 16'h0080, 16'h0080, 16'h0200,
    16'h1FFF, 16'h1FFF, 16'h0067, 16'h0068, 16'h0068, 16'h0068, 16'h0068};
  localparam logic [11:0] AOE = 12'h4B5;
  localparam logic [11:0] AFLAG = 12'h2B5;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [15:0] conv_data;
  logic        conv_done;
  logic        conv_start;
  logic        conv_bus;
  logic        adc_sleep;
  logic        alert_out;
  logic        alert_oe;
  logic        slow = 1'b0;
  logic [15:0] shunt_val = 16'h0100;
  logic [15:0] bus_val = 16'h2000;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          n_start = 0;
  int          n_bstart = 0;
  int          n_done = 0;
  int          cycles = 0;
  pmca_monitor #(.RECOVERY_CYCLES(4)) uut (.ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .conv_done(conv_done), .conv_data(conv_data), .conv_start(conv_start),
    .conv_bus(conv_bus), .conv_time(), .adc_sleep(adc_sleep), .alert_out(alert_out),
    .alert_oe(alert_oe));
  pmca_conv_model far (.ref_clk(ref_clk), .rst(rst), .conv_start(conv_start),
    .conv_bus(conv_bus), .slow(slow), .shunt_val(shunt_val), .bus_val(bus_val),
    .conv_done(conv_done), .conv_data(conv_data));
  always #2.5 ref_clk = ~ref_clk;
  // event counts and hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (conv_start) n_start++;
    if (conv_start && conv_bus) n_bstart++;
    if (conv_done) n_done++;
    if (cycles > 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask
  // read one register and compare the masked bits
  task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] exp);
    @(negedge ref_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    chk(reg_rdata & m, exp);
  endtask
  // wait for a number of conversions, then for the result and alert to land
  task automatic wait_done(input int n);
    for (int i = 0; i < 3000 && n_done < n; i++) @(negedge ref_clk);
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic run(input logic [15:0] cfg, input int n);
    wr(8'h00, cfg);
    n_start = 0;
    n_bstart = 0;
    n_done = 0;
    wait_done(n);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    rd(8'h00, 16'hFFFF, pmca_pkg::CFG_RESET);
    rd(8'h07, 16'hFFFF, 16'h0000);
    rd(8'h08, 16'hFFFF, 16'h0000);
    $display("test reset done");
    wr(8'h00, 16'h0000);
    n_start = 0;
    repeat (40) @(negedge ref_clk);
    chk({15'h0000, adc_sleep}, 16'h0001);
    chk(16'(n_start), 16'h0000);
    wr(8'h07, 16'h1234);
    rd(8'h07, 16'hFFFF, 16'h1234);
    wr(8'h01, 16'hFFFF);
    rd(8'h01, 16'hFFFF, 16'h0000);
    wr(8'h06, 16'hFFFF);
    rd(8'h06, 16'hFFFF, pmca_pkg::MSK_WRITABLE);
    wr(8'h06, 16'h0000);
    $display("test power-down done");
    for (int m = 1; m <= 3; m++) begin
      run({13'h0000, 3'(m)}, m == 3 ? 2 : 1);
      repeat (20) @(negedge ref_clk);
      chk(16'(n_start), m == 3 ? 16'h0002 : 16'h0001);
      chk(16'(n_bstart), m == 1 ? 16'h0000 : 16'h0001);
    end
    rd(8'h04, 16'hFFFF, 16'h0000);
    rd(8'h03, 16'hFFFF, 16'h0000);
    rd(8'h06, 16'h0008, 16'h0008);
    rd(8'h06, 16'h0008, 16'h0000);
    $display("test modes done");
    wr(8'h05, 16'h0800);
    run(16'h0003, 2);
    rd(8'h01, 16'hFFFF, 16'h0100);
    rd(8'h02, 16'hFFFF, 16'h2000);
    rd(8'h04, 16'hFFFF, 16'h0100);
    rd(8'h03, 16'hFFFF, 16'h0068);
    wr(8'h00, 16'h0003);
    rd(8'h06, 16'h0008, 16'h0000);
    shunt_val = 16'h0200;
    slow = 1'b1;
    run(16'h035B, 6);
    rd(8'h01, 16'hFFFF, 16'h0100);
    wait_done(8);
    rd(8'h01, 16'hFFFF, 16'h0200);
    rd(8'h04, 16'hFFFF, 16'h0200);
    rd(8'h03, 16'hFFFF, 16'h00D1);
    chk(16'(n_start), 16'h0008);
    slow = 1'b0;
    shunt_val = 16'h0100;
    $display("test averaging done");
    for (int k = 0; k < 12; k++) begin
      wr(8'h06, AMASK[k]);
      wr(8'h07, ALIM[k]);
      run(16'h0003, 2);
      chk({15'h0000, alert_oe}, {15'h0000, AOE[k]});
      rd(8'h06, 16'h0010, {11'h000, AFLAG[k], 4'h0});
    end
    $display("test alert table done");
    wr(8'h06, 16'h8001);
    wr(8'h07, 16'h0080);
    run(pmca_pkg::CFG_RESET, 4);
    chk({15'h0000, alert_oe}, 16'h0001);
    shunt_val = 16'h0010;
    n_done = 0;
    wait_done(4);
    chk({15'h0000, alert_oe}, 16'h0001);
    chk({15'h0000, n_bstart >= 4}, 16'h0001);
    rd(8'h06, 16'h0010, 16'h0010);
    n_done = 0;
    wait_done(4);
    chk({15'h0000, alert_oe}, 16'h0000);
    $display("test latch done");
    summarize();
  end
endmodule
`default_nettype wire
